// ---- common/isc_map.vh ----
`ifndef ISC_MAP_VH
`define ISC_MAP_VH

// special opcodes seen on the instruction bus (bit 15 = first bit on the bus)
`define ISC_OP_MASK_SET    16'h0505
`define ISC_OP_MASK_CLEAR  16'h0404
`define ISC_OP_RETURN      16'h0606
`define ISC_OP_PUSH        16'h0303
`define ISC_OP_FLUSH       16'h0202

// widths
`define ISC_IW             16
`define ISC_AW             13
`define ISC_NREQ           3
`define ISC_LVLW           2

// forced jump word layout
`define ISC_JMP_OP_MSB     15
`define ISC_JMP_OP_LSB     13
`define ISC_VECTOR_BASE    13'h0004
`define ISC_ADDR_ZERO      13'h0000
`define ISC_ADDR_LSB_ONE   13'h0001

// priority level meaning no routine in service
`define ISC_LVL_NONE       2'h3

// register byte offsets
`define ISC_REG_CTRL       4'h0
`define ISC_REG_STATUS     4'h4
`define ISC_REG_STACK_TOP  4'h8

// ctrl fields
`define ISC_CTRL_SW_DIS    0
`define ISC_CTRL_RESET     32'h0000_0000

// status fields
`define ISC_ST_PEND_LSB    0
`define ISC_ST_MASK        4
`define ISC_ST_DIS         5
`define ISC_ST_FULL        6
`define ISC_ST_DEPTH_LSB   8
`define ISC_ST_LVL_LSB     12
`define ISC_ST_STATE_LSB   16

// axi responses
`define ISC_RESP_OKAY      2'h0
`define ISC_RESP_DECERR    2'h3

`endif

// ---- src/isc_core.v ----
// What this block does
// - mask-set opcode sets the interrupt mask
// - mask-clear opcode clears the interrupt mask
// - return opcode pops stack, jumps there
// - push opcode stacks next address, LSB forced one
// - flush opcode clears pending requests only
// - opcodes decoded straight off the bus
// - inhibited requests stay latched for later
// - edges still latch while inhibited
// - mask set at address zero and servicing
// - interrupt-entry return clears mask, subroutine not
// - disable input suspends servicing, mask untouched
// - no servicing during execute-indirect
// - no servicing during push/return and next
// - address zero: no latch, service, decode
// - four-entry LIFO of 13-bit addresses
// - stack-full high until return or reset
// - full-stack push overwrites oldest entry
// - full flag may be wrong after overflow
// - per-entry interrupt/subroutine flag decides mask
// - address zero resets drivers, latches, stack
// - edge requests, line 0 highest priority
// - only strictly higher priority preempts
// - service: halt one cycle, jump vector, release
// - return: halt one cycle, jump popped, release
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "isc_map.vh"
module isc_core #(
   parameter [2:0] JMP_OPCODE  = 3'h7,
   parameter [2:0] XEC_OPCODE  = 3'h4,
   parameter       STK_DEPTH   = 4
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [15:0] instr_in,
   output reg  [15:0] instr_out,
   output reg         instr_oe_n,
   input  wire [12:0] addr_in,
   input  wire [2:0]  int_req,
   input  wire        service_disable_in,
   output reg         halt_n,
   output reg         rom_disable,
   output reg         stack_full_out,
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);

   // one-hot sequencer states
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_HALT = 4'b0010;
   localparam [3:0] ST_JUMP = 4'b0100;
   localparam [3:0] ST_REL  = 4'b1000;

   // highest-priority set bit as a level, none if empty
   function [1:0] prio_level;
      input [2:0] req;
      begin
         if (req[0]) begin
            prio_level = 2'h0;
         end else if (req[1]) begin
            prio_level = 2'h1;
         end else if (req[2]) begin
            prio_level = 2'h2;
         end else begin
            prio_level = `ISC_LVL_NONE;
         end
      end
   endfunction

   // synchronisers, latches, sequencer and stack storage
   reg  [2:0]  req_s1_ff;
   reg  [2:0]  req_s2_ff;
   reg  [2:0]  req_prev_ff;
   reg         dis_s1_ff;
   reg         dis_s2_ff;
   reg  [2:0]  pend_ff;
   reg         mask_ff;
   reg         supp_ff;
   reg  [3:0]  state_ff;
   reg         is_ret_ff;
   reg  [1:0]  svc_lvl_ff;
   reg  [12:0] jmp_tgt_ff;
   reg         ret_intr_ff;
   reg  [2:0]  depth_ff;
   reg  [31:0] ctrl_ff;
   reg  [12:0] stk_addr_ff [0:STK_DEPTH-1];
   reg         stk_intr_ff [0:STK_DEPTH-1];
   reg  [1:0]  stk_lvl_ff  [0:STK_DEPTH-1];

   // next values, in-service levels and loop indices
   reg  [2:0]  nxt_pend;
   reg         nxt_mask;
   reg  [3:0]  nxt_state;
   reg  [2:0]  in_svc;
   integer     i;
   integer     j;

   // special opcodes decoded off address zero and only while idle, execute-indirect always
   wire        at_zero   = (addr_in == `ISC_ADDR_ZERO);
   wire        dec_ok    = ~at_zero & state_ff[0];
   wire        op_mset   = dec_ok & (instr_in == `ISC_OP_MASK_SET);
   wire        op_mclr   = dec_ok & (instr_in == `ISC_OP_MASK_CLEAR);
   wire        op_ret    = dec_ok & (instr_in == `ISC_OP_RETURN);
   wire        op_push   = dec_ok & (instr_in == `ISC_OP_PUSH);
   wire        op_flush  = dec_ok & (instr_in == `ISC_OP_FLUSH);
   wire        op_xec    = (instr_in[`ISC_JMP_OP_MSB:`ISC_JMP_OP_LSB] == XEC_OPCODE);

   // request edges, inhibit sources and priority levels
   wire [2:0]  new_edge  = req_s2_ff & ~req_prev_ff;
   wire        inhibit   = mask_ff | dis_s2_ff | ctrl_ff[`ISC_CTRL_SW_DIS];
   wire [1:0]  best_lvl  = prio_level(pend_ff);
   wire [1:0]  cur_lvl   = prio_level(in_svc);
   wire        stk_full  = (depth_ff == STK_DEPTH[2:0]);

   // grant: pending line beats the level in service and nothing blocks
   wire        grant = dec_ok & ~inhibit & ~op_xec & ~op_push & ~op_ret & ~supp_ff
                       & (best_lvl != `ISC_LVL_NONE) & (best_lvl < cur_lvl);

   // levels of interrupt routines currently on the stack
   always @* begin
      in_svc = 3'h0;
      for (i = 0; i < STK_DEPTH; i = i + 1) begin
         if ((i < depth_ff) && stk_intr_ff[i]) begin
            in_svc[stk_lvl_ff[i]] = 1'b1;
         end
      end
   end

   // request latches: edge sets win over flush and grant clears
   always @* begin
      nxt_pend = pend_ff;
      if (op_flush) begin
         nxt_pend = 3'h0;
      end
      if (grant) begin
         nxt_pend[best_lvl] = 1'b0;
      end
      nxt_pend = nxt_pend | new_edge;
      if (at_zero) begin
         nxt_pend = 3'h0;
      end
   end

   // mask: sets take precedence over clears
   always @* begin
      nxt_mask = mask_ff;
      if (op_mclr) begin
         nxt_mask = 1'b0;
      end
      if (state_ff[3] & is_ret_ff & ret_intr_ff) begin
         nxt_mask = 1'b0;
      end
      if (op_mset | grant | at_zero) begin
         nxt_mask = 1'b1;
      end
   end

   // sequencer: idle, halt cycle, forced jump, release
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (grant | op_ret) begin
               nxt_state = ST_HALT;
            end
         end
         ST_HALT: nxt_state = ST_JUMP;
         ST_JUMP: nxt_state = ST_REL;
         ST_REL:  nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
      if (at_zero) begin
         nxt_state = ST_IDLE;
      end
   end

   // input synchronisers and edge history
   always @(posedge aclk) begin
      if (!aresetn) begin
         req_s1_ff   <= 3'h0;
         req_s2_ff   <= 3'h0;
         req_prev_ff <= 3'h0;
         dis_s1_ff   <= 1'b0;
         dis_s2_ff   <= 1'b0;
      end else begin
         req_s1_ff   <= int_req;
         req_s2_ff   <= req_s1_ff;
         req_prev_ff <= req_s2_ff;
         dis_s1_ff   <= service_disable_in;
         dis_s2_ff   <= dis_s1_ff;
      end
   end

   // control state, sequencer and pin outputs
   always @(posedge aclk) begin
      if (!aresetn) begin
         pend_ff     <= 3'h0;
         mask_ff     <= 1'b1;
         supp_ff     <= 1'b0;
         state_ff    <= ST_IDLE;
         is_ret_ff   <= 1'b0;
         svc_lvl_ff  <= `ISC_LVL_NONE;
         jmp_tgt_ff  <= `ISC_ADDR_ZERO;
         ret_intr_ff <= 1'b0;
         halt_n      <= 1'b1;
         rom_disable <= 1'b0;
         instr_oe_n  <= 1'b1;
         instr_out   <= 16'h0000;
      end else begin
         pend_ff  <= nxt_pend;
         mask_ff  <= nxt_mask;
         state_ff <= nxt_state;
         supp_ff  <= op_push | op_ret | state_ff[3];
         // target and return kind latched as a sequence starts
         if (state_ff[0] & grant) begin
            is_ret_ff  <= 1'b0;
            svc_lvl_ff <= best_lvl;
            jmp_tgt_ff <= `ISC_VECTOR_BASE + {11'h000, best_lvl};
         end else if (state_ff[0] & op_ret) begin
            is_ret_ff   <= 1'b1;
            jmp_tgt_ff  <= stk_addr_ff[0];
            ret_intr_ff <= stk_intr_ff[0];
         end
         // halt for one cycle, then drive the jump; memory disable spans halt and jump
         halt_n      <= ~(nxt_state[1]);
         rom_disable <= nxt_state[1] | nxt_state[2];
         instr_oe_n  <= ~nxt_state[2];
         if (nxt_state[2]) begin
            instr_out <= {JMP_OPCODE, jmp_tgt_ff};
         end
         // address zero overrides any takeover in progress
         if (at_zero) begin
            halt_n      <= 1'b1;
            rom_disable <= 1'b0;
            instr_oe_n  <= 1'b1;
            supp_ff     <= 1'b0;
         end
      end
   end

   // return stack, top at index 0, push shifts the oldest out
   always @(posedge aclk) begin
      if (!aresetn) begin
         depth_ff       <= 3'h0;
         stack_full_out <= 1'b0;
         for (j = 0; j < STK_DEPTH; j = j + 1) begin
            stk_addr_ff[j] <= `ISC_ADDR_ZERO;
            stk_intr_ff[j] <= 1'b0;
            stk_lvl_ff[j]  <= `ISC_LVL_NONE;
         end
      end else if (at_zero) begin
         depth_ff       <= 3'h0;
         stack_full_out <= 1'b0;
      end else if (op_push | (state_ff[1] & ~is_ret_ff)) begin
         for (j = STK_DEPTH - 1; j > 0; j = j - 1) begin
            stk_addr_ff[j] <= stk_addr_ff[j-1];
            stk_intr_ff[j] <= stk_intr_ff[j-1];
            stk_lvl_ff[j]  <= stk_lvl_ff[j-1];
         end
         if (op_push) begin
            stk_addr_ff[0] <= addr_in | `ISC_ADDR_LSB_ONE;
            stk_intr_ff[0] <= 1'b0;
            stk_lvl_ff[0]  <= `ISC_LVL_NONE;
         end else begin
            stk_addr_ff[0] <= addr_in;
            stk_intr_ff[0] <= 1'b1;
            stk_lvl_ff[0]  <= svc_lvl_ff;
         end
         if (!stk_full) begin
            depth_ff <= depth_ff + 3'h1;
         end
         stack_full_out <= stack_full_out | (depth_ff >= STK_DEPTH[2:0] - 3'h1);
      end else if (state_ff[2] & is_ret_ff) begin
         for (j = 0; j < STK_DEPTH - 1; j = j + 1) begin
            stk_addr_ff[j] <= stk_addr_ff[j+1];
            stk_intr_ff[j] <= stk_intr_ff[j+1];
            stk_lvl_ff[j]  <= stk_lvl_ff[j+1];
         end
         stk_intr_ff[STK_DEPTH-1] <= 1'b0;
         if (depth_ff != 3'h0) begin
            depth_ff <= depth_ff - 3'h1;
         end
         stack_full_out <= 1'b0;
      end
   end

   // axi4-lite write: address and data taken together
   wire       wr_go   = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   wire [3:0] wr_off  = s_axi_awaddr[3:0];
   wire       wr_hit  = (s_axi_awaddr[31:4] == 28'h0000000) & (wr_off == `ISC_REG_CTRL);

   // address and data only ever accepted together
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;

   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_ff      <= `ISC_CTRL_RESET;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `ISC_RESP_OKAY;
      end else begin
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `ISC_RESP_OKAY : `ISC_RESP_DECERR;
            if (wr_hit & s_axi_wstrb[0]) begin
               ctrl_ff[`ISC_CTRL_SW_DIS] <= s_axi_wdata[`ISC_CTRL_SW_DIS];
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // axi4-lite read: control, status and stack top
   wire       rd_go  = s_axi_arvalid & ~s_axi_rvalid;
   wire [3:0] rd_off = s_axi_araddr[3:0];
   wire       rd_hi0 = (s_axi_araddr[31:4] == 28'h0000000);

   // a new address waits until the last answer is taken
   assign s_axi_arready = ~s_axi_rvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `ISC_RESP_OKAY;
      end else begin
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `ISC_RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            if (rd_hi0 && rd_off == `ISC_REG_CTRL) begin
               s_axi_rdata <= ctrl_ff;
            end else if (rd_hi0 && rd_off == `ISC_REG_STATUS) begin
               s_axi_rdata[`ISC_ST_PEND_LSB+2:`ISC_ST_PEND_LSB]   <= pend_ff;
               s_axi_rdata[`ISC_ST_MASK]                          <= mask_ff;
               s_axi_rdata[`ISC_ST_DIS]                           <= dis_s2_ff;
               s_axi_rdata[`ISC_ST_FULL]                          <= stack_full_out;
               s_axi_rdata[`ISC_ST_DEPTH_LSB+2:`ISC_ST_DEPTH_LSB] <= depth_ff;
               s_axi_rdata[`ISC_ST_LVL_LSB+1:`ISC_ST_LVL_LSB]     <= cur_lvl;
               s_axi_rdata[`ISC_ST_STATE_LSB+3:`ISC_ST_STATE_LSB] <= state_ff;
            end else if (rd_hi0 && rd_off == `ISC_REG_STACK_TOP) begin
               s_axi_rdata[12:0] <= stk_addr_ff[0];
               s_axi_rdata[13]   <= stk_intr_ff[0];
            end else begin
               s_axi_rresp <= `ISC_RESP_DECERR;
            end
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule

// ---- sim/isc_checker.sv ----
`timescale 1ns/1ps
`include "isc_map.vh"
module isc_checker #(
   parameter [2:0] JMP_OPCODE = 3'h7,
   parameter [2:0] XEC_OPCODE = 3'h4
) (
   input wire        aclk,
   input wire        aresetn,
   input wire [15:0] instr_in,
   input wire [15:0] instr_out,
   input wire        instr_oe_n,
   input wire [12:0] addr_in,
   input wire        halt_n,
   input wire        rom_disable,
   input wire        stack_full_out
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // no takeover running, opcodes decodable
   wire idle = halt_n && instr_oe_n && !rom_disable && (addr_in != 13'h0);

   a_halt_one: assert property ($fell(halt_n) |=> halt_n)
      else $error("halt held too long");
   a_jump_next: assert property (!halt_n |=> !instr_oe_n && rom_disable)
      else $error("no jump after halt");
   a_rom_two: assert property ($rose(rom_disable) |-> !halt_n ##1 rom_disable ##1 !rom_disable)
      else $error("memory disable width wrong");
   a_oe_one: assert property (!instr_oe_n |=> instr_oe_n && !rom_disable)
      else $error("bus not released");
   a_jump_code: assert property (!instr_oe_n |-> instr_out[15:13] == JMP_OPCODE)
      else $error("forced word not a jump");
   a_zero_reset: assert property (addr_in == 13'h0 |=> halt_n && instr_oe_n && !stack_full_out)
      else $error("address zero did not reset");
   a_push_quiet: assert property (idle && instr_in == `ISC_OP_PUSH |=> halt_n ##1 halt_n)
      else $error("service right after push");
   a_xec_quiet: assert property (idle && instr_in[15:13] == XEC_OPCODE |=> halt_n)
      else $error("service during execute-indirect");
   a_full_hold: assert property (stack_full_out && idle |=> stack_full_out)
      else $error("full flag dropped early");
endmodule

// ---- sim/isc_cpu_model.sv ----
`timescale 1ns/1ps
module isc_cpu_model (
   input  wire        aclk,
   input  wire [12:0] pc,
   input  wire [15:0] rom_word,
   input  wire        rom_disable,
   input  wire        instr_oe_n,
   input  wire [15:0] instr_out,
   output reg  [15:0] instr_in,
   output wire [12:0] addr_in
);
   reg [15:0] last_ff;
   // address bus already shows the next fetch
   assign addr_in = pc;
   // remember bus value so a floating bus never repeats it
   always @(posedge aclk) begin
      last_ff <= instr_in;
   end
   // bus owner: coprocessor, else memory, else floating
   always @* begin
      if (!instr_oe_n)
         instr_in = instr_out;
      else if (!rom_disable)
         instr_in = rom_word;
      else
         instr_in = ~last_ff;
   end
endmodule

// ---- sim/interrupt_subroutine_coprocessor_tb_top.sv ----
`timescale 1ns/1ps
`include "isc_map.vh"
module interrupt_subroutine_coprocessor_tb_top;
   localparam [2:0] JMP = 3'h7;
   reg         aclk = 1'b0;
   reg         aresetn = 1'b0;
   reg  [12:0] pc = 13'h0100;
   reg  [15:0] rom_word = 16'h0000;
   reg  [2:0]  int_req = 3'h0;
   reg         service_disable_in = 1'b0;
   reg  [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   reg  [3:0]  s_axi_wstrb = 4'hf;
   reg         s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   wire [15:0] instr_in, instr_out;
   wire [12:0] addr_in;
   wire        instr_oe_n, halt_n, rom_disable, stack_full_out;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   reg  [22:0] rows [0:4] = '{{`ISC_OP_MASK_SET, 7'h16}, {`ISC_OP_FLUSH, 7'h10},
      {`ISC_OP_MASK_CLEAR, 7'h00}, {`ISC_OP_MASK_SET, 7'h10}, {16'h8000, 7'h10}};
   reg  [31:0] d;
   reg  [1:0]  r;
   integer     fails = 0, compares = 0, i, k;

   // processor master clock
   always #12.5 aclk = ~aclk;

   isc_core dut (.aclk, .aresetn, .instr_in, .instr_out, .instr_oe_n, .addr_in, .int_req,
      .service_disable_in, .halt_n, .rom_disable, .stack_full_out, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   isc_cpu_model cpu (.aclk, .pc, .rom_word, .rom_disable, .instr_oe_n, .instr_out,
      .instr_in, .addr_in);

   task print_verdict;
      begin
         if (fails == 0 && compares > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask

   task chk(input [31:0] g, input [31:0] e);
      begin
         compares = compares + 1;
         if (g !== e) begin
            fails = fails + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask

   // present address bus and executed word for n cycles
   task cyc(input [12:0] a, input [15:0] w, input integer n);
      begin
         pc <= a;
         rom_word <= w;
         repeat (n) @(posedge aclk);
      end
   endtask

   // rising edge on request lines, low again before next one
   task pulse(input [2:0] m);
      begin
         int_req <= m;
         repeat (2) @(posedge aclk);
         int_req <= 3'h0;
         repeat (4) @(posedge aclk);
      end
   endtask

   // wait for forced jump, compare target, let release finish
   task jmp(input [12:0] tgt);
      begin
         i = 0;
         #1; // after a return the jump may already stand
         while (instr_oe_n !== 1'b0 && i < 20) begin
            @(posedge aclk);
            #1;
            i = i + 1;
         end
         chk({16'h0, instr_out}, {16'h0, JMP, tgt});
         repeat (2) @(posedge aclk);
      end
   endtask

   task axw(input [31:0] a, input [31:0] dd);
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= dd;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         @(posedge aclk);
         while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1)) @(posedge aclk);
         s_axi_awvalid <= 1'b0;
         s_axi_wvalid <= 1'b0;
         @(posedge aclk);
         while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      end
   endtask

   task axr(input [31:0] a, output [31:0] dd, output [1:0] rr);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         @(posedge aclk);
         while (s_axi_arready !== 1'b1) @(posedge aclk);
         s_axi_arvalid <= 1'b0;
         @(posedge aclk);
         while (s_axi_rvalid !== 1'b1) @(posedge aclk);
         dd = s_axi_rdata;
         rr = s_axi_rresp;
      end
   endtask

   // watchdog against a hung handshake
   initial begin
      #100000;
      fails = fails + 1;
      print_verdict;
   end

   // main sequence
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk({28'h0, halt_n, instr_oe_n, rom_disable, stack_full_out}, 32'hc);
      axr(32'h4, d, r);
      chk(d & 32'h7f, 32'h10);
      pulse(3'b110);
      for (k = 0; k < 5; k = k + 1) begin
         cyc(13'h0102, rows[k][22:7], 1);
         cyc(13'h0103, 16'h0, 1);
         axr(32'h4, d, r);
         chk(d & 32'h7f, {25'h0, rows[k][6:0]});
      end
      // two lines pending, line 1 first, no preempt by line 2
      pulse(3'b110);
      cyc(13'h0200, `ISC_OP_MASK_CLEAR, 1);
      cyc(13'h0201, 16'h0, 1);
      jmp(13'h5);
      axr(32'h4, d, r);
      chk(d & 32'h17, 32'h14);
      cyc(13'h0300, `ISC_OP_MASK_CLEAR, 1);
      cyc(13'h0301, 16'h0, 3);
      axr(32'h4, d, r);
      chk(d & 32'h307f, 32'h1004);
      cyc(13'h0310, `ISC_OP_RETURN, 1);
      cyc(13'h0311, 16'h0, 1);
      jmp(13'h0201);
      cyc(13'h0201, 16'h0, 1);
      jmp(13'h6);
      cyc(13'h0400, `ISC_OP_RETURN, 1);
      cyc(13'h0401, 16'h0, 1);
      jmp(13'h0201);
      // five subroutine pushes at even addresses, returns land on odd ones
      cyc(13'h0500, `ISC_OP_MASK_SET, 1);
      for (k = 0; k < 5; k = k + 1) begin
         cyc(13'h0502 + {k[8:0], 4'h0}, `ISC_OP_PUSH, 1);
         cyc(13'h0503 + {k[8:0], 4'h0}, 16'h0, 1);
         if (k < 4)
            chk({31'h0, stack_full_out}, {31'h0, k == 3});
      end
      for (k = 4; k > 0; k = k - 1) begin
         cyc(13'h0600, `ISC_OP_RETURN, 1);
         cyc(13'h0601, 16'h0, 1);
         jmp(13'h0503 + {k[8:0], 4'h0});
      end
      axr(32'h4, d, r);
      chk(d & 32'h10, 32'h10);
      // external disable holds off a pending request
      cyc(13'h0700, `ISC_OP_MASK_CLEAR, 1);
      service_disable_in <= 1'b1;
      cyc(13'h0701, 16'h0, 1);
      pulse(3'b001);
      axr(32'h4, d, r);
      chk(d & 32'h7f, 32'h21);
      service_disable_in <= 1'b0;
      jmp(13'h4);
      // register bus, then an unmapped read
      axw(32'h0, 32'h1);
      chk({30'h0, s_axi_bresp}, {30'h0, `ISC_RESP_OKAY});
      axr(32'h0, d, r);
      chk(d, 32'h1);
      // a write with no byte lane enabled leaves the register alone
      s_axi_wstrb <= 4'h0;
      axw(32'h0, 32'h0);
      axr(32'h0, d, r);
      chk(d, 32'h1);
      s_axi_wstrb <= 4'hf;
      axw(32'h0, 32'h0);
      axw(32'h40, 32'h0);
      chk({30'h0, s_axi_bresp}, {30'h0, `ISC_RESP_DECERR});
      axr(32'h40, d, r);
      chk({30'h0, r}, {30'h0, `ISC_RESP_DECERR});
      // address zero empties stack and ignores requests
      cyc(13'h0000, `ISC_OP_MASK_CLEAR, 1);
      pulse(3'b100);
      axr(32'h4, d, r);
      chk(d & 32'h77f, 32'h10);
      // execute-indirect, push and the cycle after push hold off service
      cyc(13'h0800, 16'h0, 1);
      pulse(3'b100);
      cyc(13'h0801, `ISC_OP_MASK_CLEAR, 1);
      cyc(13'h0802, 16'h8000, 1);
      cyc(13'h0803, `ISC_OP_PUSH, 1);
      chk({31'h0, halt_n}, 32'h1);
      cyc(13'h0804, 16'h0, 1);
      chk({31'h0, halt_n}, 32'h1);
      cyc(13'h0805, 16'h0, 1);
      chk({31'h0, halt_n}, 32'h1);
      jmp(13'h6);
      print_verdict;
   end
endmodule

bind isc_core isc_checker #(.JMP_OPCODE(JMP_OPCODE), .XEC_OPCODE(XEC_OPCODE)) u_chk (
   .aclk, .aresetn, .instr_in, .instr_out, .instr_oe_n, .addr_in, .halt_n,
   .rom_disable, .stack_full_out);
